/* File: bench/data_nv_memory_access_ctrl_bench.sv */
// self-checking bench for the nonvolatile access controller
`timescale 1ns/100ps
`default_nettype none
`include "nvac_cfg.svh"
module data_nv_memory_access_ctrl_bench import nvac_pkg::*;;
  localparam int unsigned STORE_N = 8;   // shortened store
  localparam int unsigned PWRUP_N = 16;  // shortened power-up block
  logic       i_clock = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_reg_write = 1'b0;
  logic       i_reg_read = 1'b0;
  logic [2:0] i_reg_sel = 3'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic       i_done_clear = 1'b0;
  logic [7:0] o_reg_rdata, i_array_rdata, o_array_wdata;
  logic [9:0] o_array_addr;
  logic [1:0] o_array_target;
  logic       o_nv_done_flag, o_array_fetch, o_array_erase, o_array_prog, o_array_row_wipe, o_busy;
  int         failures = 0;
  int         cmp_count = 0;
  logic [7:0] rv;                 // last register read
  logic       wipe_seen = 1'b0;   // row wipe seen
  logic [7:0] ctl_tab [4] = '{8'h01, 8'h81, 8'h41, 8'hC1};
  nvac_target_t tgt_tab [4] = '{NVAC_TGT_DATA, NVAC_TGT_PROG, NVAC_TGT_CONFIG, NVAC_TGT_CONFIG};
  logic [7:0] bad_tab [3][4] = '{'{8'h00, 8'h55, 8'hAA, 8'h06}, '{8'h84, 8'hAA, 8'h55, 8'h86},
                                 '{8'h04, 8'h55, 8'h55, 8'h06}};
  always #12.5 i_clock = ~i_clock;
  always @(posedge i_clock) if (o_array_row_wipe === 1'b1) wipe_seen <= 1'b1;
  nvac_ctrl #(.STORE_CYCLES(STORE_N), .PWRUP_CYCLES(PWRUP_N)) DUT (
    .i_clock, .i_reset, .i_reg_write, .i_reg_read, .i_reg_sel, .i_reg_wdata, .o_reg_rdata, .i_done_clear,
    .o_nv_done_flag, .o_array_addr, .o_array_wdata, .o_array_target, .o_array_fetch, .o_array_erase,
    .o_array_prog, .o_array_row_wipe, .i_array_rdata, .o_busy);
  nvac_array_model u_array (.i_clock, .i_addr(o_array_addr), .i_wdata(o_array_wdata), .i_target(o_array_target),
    .i_fetch(o_array_fetch), .i_erase(o_array_erase), .i_prog(o_array_prog), .o_rdata(i_array_rdata));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // strobe stays up so back-to-back writes are consecutive
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    i_reg_read  = 1'b0;
    i_reg_write = 1'b1;
    i_reg_sel   = sel;
    i_reg_wdata = d;
    @(posedge i_clock);
    #2;
  endtask : wr
  task automatic idle(input int n);
    i_reg_write = 1'b0;
    i_reg_read  = 1'b0;
    repeat (n) begin
      @(posedge i_clock);
      #2;
    end
  endtask : idle
  task automatic rd(input logic [2:0] sel);
    i_reg_write = 1'b0;
    i_reg_read  = 1'b1;
    i_reg_sel   = sel;
    @(posedge i_clock);
    #2;
    i_reg_read = 1'b0;
    rv = o_reg_rdata;
    @(posedge i_clock);
    #2;
  endtask : rd
  task automatic store(input logic [7:0] pre, k1, k2, go);
    wr(`NVAC_SEL_CONTROL, pre);
    wr(`NVAC_SEL_UNLOCK, k1);
    wr(`NVAC_SEL_UNLOCK, k2);
    wr(`NVAC_SEL_CONTROL, go);
  endtask : store
  task automatic wait_idle();
    int n = 0;
    idle(1);
    while (o_busy !== 1'b0 && n < 100) begin
      idle(1);
      n++;
    end
    if (n >= 100) begin
      failures++;
      $display("wrong value at %0t: store never ended", $time);
      finish_test();
    end
  endtask : wait_idle
  initial begin
    repeat (5) @(posedge i_clock);
    #2;
    i_reset = 1'b0;
    // ---------------------------------------------------------------
    // reset state and store during power-up block
    // ---------------------------------------------------------------
    rd(`NVAC_SEL_CONTROL);
    chk(rv & 8'h27, 8'h00);
    rd(`NVAC_SEL_UNLOCK);
    chk(rv, 8'h00);
    wr(`NVAC_SEL_ADDR_HIGH, 8'hFF);
    wr(`NVAC_SEL_ADDR_LOW, 8'hA5);
    wr(`NVAC_SEL_DATA, 8'h5C);
    store(8'h04, `NVAC_KEY_FIRST, `NVAC_KEY_SECOND, 8'h06);
    wait_idle();
    rd(`NVAC_SEL_CONTROL);
    chk(rv & 8'h0A, 8'h08);
    chk(u_array.mem[10'h3A5], 8'hA5 ^ 8'h3C);
    $display("test done: power-up block");
    // ---------------------------------------------------------------
    // proper store, locked registers, done flag
    // ---------------------------------------------------------------
    idle(PWRUP_N);
    store(8'h04, `NVAC_KEY_FIRST, `NVAC_KEY_SECOND, 8'h06);
    idle(2);
    wr(`NVAC_SEL_DATA, 8'h11);
    wr(`NVAC_SEL_ADDR_LOW, 8'h00);
    idle(1);
    chk(o_array_wdata, 8'h5C);
    chk(o_array_addr[7:0], 8'hA5);
    wait_idle();
    chk({7'h00, o_nv_done_flag}, 8'h01);
    rd(`NVAC_SEL_CONTROL);
    chk(rv & 8'h0A, 8'h00);
    chk(u_array.mem[10'h3A5], 8'h5C);
    i_done_clear = 1'b1;
    idle(1);
    i_done_clear = 1'b0;
    idle(1);
    chk({7'h00, o_nv_done_flag}, 8'h00);
    $display("test done: store");
    // fetch and refused fetches across all target spaces
    for (int k = 0; k < 4; k++) begin
      wr(`NVAC_SEL_DATA, 8'h77);
      wr(`NVAC_SEL_CONTROL, ctl_tab[k]);
      idle(1);
      chk({6'h00, o_array_target}, {6'h00, tgt_tab[k]});
      rd(`NVAC_SEL_DATA);
      chk(rv, (k == 0) ? 8'h5C : 8'h77);
    end
    $display("test done: fetch");
    // broken sequences: no store, fault set, selects kept
    for (int k = 0; k < 3; k++) begin
      store(bad_tab[k][0], bad_tab[k][1], bad_tab[k][2], bad_tab[k][3]);
      wait_idle();
      rd(`NVAC_SEL_CONTROL);
      chk(rv & 8'hCA, (bad_tab[k][0] & 8'hC0) | 8'h08);
      chk(u_array.mem[10'h3A5], 8'h5C);
    end
    $display("test done: refused stores");
    // row wipe in program space
    store(8'h94, `NVAC_KEY_FIRST, `NVAC_KEY_SECOND, 8'h96);
    wait_idle();
    chk({7'h00, wipe_seen}, 8'h01);
    rd(`NVAC_SEL_CONTROL);
    chk(rv & 8'h1A, 8'h00);
    chk(u_array.mem[10'h3A5], 8'h5C);
    $display("test done: row wipe");
    // reset in mid-store leaves the fault flag
    store(8'h04, `NVAC_KEY_FIRST, `NVAC_KEY_SECOND, 8'h06);
    idle(3);
    i_reset = 1'b1;
    idle(5);
    i_reset = 1'b0;
    idle(1);  // fault is recorded at the clock edges while reset is held
    rd(`NVAC_SEL_CONTROL);
    chk(rv & 8'hCA, 8'h08);
    $display("test done: aborted store");
    finish_test();
  end
endmodule : data_nv_memory_access_ctrl_bench
`default_nettype wire

/* File: bench/nvac_array_model.sv */
// behavioural model of the nonvolatile data array
`timescale 1ns/100ps
`default_nettype none
module nvac_array_model (
  // clock
  input  wire logic       i_clock,
  // controller side
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [1:0] i_target,
  input  wire logic       i_fetch,
  input  wire logic       i_erase,
  input  wire logic       i_prog,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [0:1023];  // byte cells, 10-bit index
  logic [7:0] last_q = 8'h00;  // last byte driven
  initial for (int k = 0; k < 1024; k++) mem[k] = k[7:0] ^ 8'h3C;
  // program only clears bits, so a skipped erase leaves a wrong byte
  always @(posedge i_clock) begin
    if (i_target == 2'h0 && i_erase) mem[i_addr] <= 8'hFF;
    if (i_target == 2'h0 && i_prog) mem[i_addr] <= mem[i_addr] & i_wdata;
    if (i_fetch) last_q <= mem[i_addr];
  end
  // released bus shows the inverse of the last byte
  assign o_rdata = i_fetch ? mem[i_addr] : ~last_q;
endmodule : nvac_array_model
`default_nettype wire

/* File: bench/nvac_ctrl_chk.sv */
// concurrent checks on the nonvolatile access controller ports
`timescale 1ns/100ps
`default_nettype none
module nvac_ctrl_chk #(
  parameter int unsigned STORE_CYCLES = 8,  // store length in cycles
  parameter int unsigned PWRUP_CYCLES = 4,  // power-up store block
  parameter int unsigned ADDR_W       = 10  // array address width
) (
  // clock and reset
  input wire logic              i_clock,
  input wire logic              i_reset,
  // register port
  input wire logic              i_reg_write,
  input wire logic              i_reg_read,
  input wire logic [2:0]        i_reg_sel,
  input wire logic [7:0]        i_reg_wdata,
  input wire logic [7:0]        o_reg_rdata,
  input wire logic              i_done_clear,
  input wire logic              o_nv_done_flag,
  // array side
  input wire logic [ADDR_W-1:0] o_array_addr,
  input wire logic [7:0]        o_array_wdata,
  input wire logic [1:0]        o_array_target,
  input wire logic              o_array_fetch,
  input wire logic              o_array_erase,
  input wire logic              o_array_prog,
  input wire logic              o_array_row_wipe,
  input wire logic [7:0]        i_array_rdata,
  input wire logic              o_busy
);
  // busy length and age since reset; wide so no run can wrap them
  logic [31:0] busy_n_ff;
  logic [31:0] age_ff;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      busy_n_ff <= '0;
      age_ff    <= '0;
    end else begin
      busy_n_ff <= o_busy ? busy_n_ff + 32'h1 : '0;
      age_ff    <= (age_ff < PWRUP_CYCLES) ? age_ff + 32'h1 : age_ff;
    end
  end
  wire ctl_wr = i_reg_write && i_reg_sel == 3'h0;  // control register write
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_unlock_reads_zero:
    assert property ($past(i_reg_read && i_reg_sel == 3'h1) |-> o_reg_rdata == 8'h00) else $error("unlock read not zero");
  a_addr_high_bits:
    assert property (i_reg_write && !o_busy && i_reg_sel == 3'h4 |=> o_array_addr[ADDR_W-1:8] == $past(i_reg_wdata[1:0]))
    else $error("high address bits wrong");
  a_fetch_one_pulse:
    assert property (ctl_wr && !o_busy && i_reg_wdata[7:6] == 2'h0 && i_reg_wdata[0] |=> o_array_fetch ##1 !o_array_fetch)
    else $error("fetch pulse wrong");
  a_fetch_refused:
    assert property (ctl_wr && i_reg_wdata[0] && i_reg_wdata[7:6] != 2'h0 |=> !o_array_fetch) else $error("fetch not refused");
  a_fetch_to_data:
    assert property (o_array_fetch ##1 (i_reg_read && i_reg_sel == 3'h2) |=> o_reg_rdata == $past(i_array_rdata, 2))
    else $error("fetched byte not returned");
  a_store_length:
    assert property ($fell(o_busy) |-> busy_n_ff == STORE_CYCLES) else $error("store length wrong");
  a_done_at_end:
    assert property ($fell(o_busy) |-> o_nv_done_flag) else $error("done flag not set");
  a_done_sticky:
    assert property (o_nv_done_flag && !i_done_clear |=> o_nv_done_flag) else $error("done flag dropped");
  a_erase_first:
    assert property ($rose(o_busy) && o_array_target == 2'h0 |-> o_array_erase && !o_array_prog) else $error("no erase first");
  a_data_locked:
    assert property (o_busy && i_reg_write && i_reg_sel == 3'h2 |=> $stable(o_array_wdata)) else $error("data changed in store");
  a_pwrup_block:
    assert property ($rose(o_busy) |-> age_ff >= PWRUP_CYCLES) else $error("store during power-up");
  a_wipe_in_store:
    assert property (o_array_row_wipe |-> o_busy && o_array_target == 2'h1) else $error("row wipe outside store");
endmodule : nvac_ctrl_chk
bind nvac_ctrl nvac_ctrl_chk #(.STORE_CYCLES(STORE_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES), .ADDR_W(ADDR_W)) u_chk (
  .i_clock, .i_reset, .i_reg_write, .i_reg_read, .i_reg_sel, .i_reg_wdata, .o_reg_rdata, .i_done_clear,
  .o_nv_done_flag, .o_array_addr, .o_array_wdata, .o_array_target, .o_array_fetch, .o_array_erase,
  .o_array_prog, .o_array_row_wipe, .i_array_rdata, .o_busy
);
`default_nettype wire

/* File: rtl/nvac_cfg.svh */
// constants for the nonvolatile data access controller
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH
// register select codes on the special function register port
`define NVAC_SEL_CONTROL   3'h0
`define NVAC_SEL_UNLOCK    3'h1
`define NVAC_SEL_DATA      3'h2
`define NVAC_SEL_ADDR_LOW  3'h3
`define NVAC_SEL_ADDR_HIGH 3'h4
// control register field positions
`define NVAC_BIT_FLASH     7
`define NVAC_BIT_CONFIG    6
`define NVAC_BIT_ROW_WIPE  4
`define NVAC_BIT_FAULT     3
`define NVAC_BIT_ALLOW     2
`define NVAC_BIT_STORE_GO  1
`define NVAC_BIT_FETCH_GO  0
// unlock sequence keys
`define NVAC_KEY_FIRST     8'h55
`define NVAC_KEY_SECOND    8'hAA
// timing
`define NVAC_CLOCK_MHZ     40
`define NVAC_STORE_TIME_US 4000
`define NVAC_STORE_CYCLES  (`NVAC_STORE_TIME_US * `NVAC_CLOCK_MHZ)
`define NVAC_PWRUP_TIME_US 1000
`define NVAC_PWRUP_CYCLES  (`NVAC_PWRUP_TIME_US * `NVAC_CLOCK_MHZ)
`endif

/* File: rtl/nvac_ctrl.sv */
// nonvolatile data memory access controller: control, unlock, data and address registers
//
// Function
// - 10-bit address from high[1:0] and low
// - flash and config selects clear target data array
// - config select set targets configuration space
// - store allow clear at reset, gates stores
// - fault flag on reset-aborted or improper store
// - store go set-only, cleared at completion
// - done flag set at completion, software clears
// - fetch go ignored when flash/config selected
// - fetch loads data in one cycle, self-clears
// - data holds until next fetch or write
// - unlock port stores nothing, reads zero
// - data byte store erases then programs, program space byte store programs only, self-timed
// - row wipe erases row, cleared at completion
// - fault leaves flash and config selects
// - 55h then AAh then store go
// - allow must be set by earlier access
// - registers locked while store runs
// - stores blocked during power-up timer
`timescale 1ns/100ps
`default_nettype none
`include "nvac_cfg.svh"

module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = `NVAC_STORE_CYCLES,  // self-timed store length
  parameter int unsigned PWRUP_CYCLES = `NVAC_PWRUP_CYCLES,  // power-up store block
  parameter int unsigned ADDR_W       = 10                   // array address width
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // register port from the core
  input  wire logic              i_reg_write,
  input  wire logic              i_reg_read,
  input  wire logic [2:0]        i_reg_sel,
  input  wire logic [7:0]        i_reg_wdata,
  output logic      [7:0]        o_reg_rdata,
  // done flag clear from the peripheral flag register
  input  wire logic              i_done_clear,
  output logic                   o_nv_done_flag,
  // array side
  output logic      [ADDR_W-1:0] o_array_addr,
  output logic      [7:0]        o_array_wdata,
  output logic      [1:0]        o_array_target,
  output logic                   o_array_fetch,
  output logic                   o_array_erase,
  output logic                   o_array_prog,
  output logic                   o_array_row_wipe,
  input  wire logic [7:0]        i_array_rdata,
  // status
  output logic                   o_busy
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // target space from the two select bits
  function automatic logic [1:0] target_of(input logic flash_sel, input logic cfg_sel);
    if (cfg_sel) begin
      target_of = NVAC_TGT_CONFIG;
    end else if (flash_sel) begin
      target_of = NVAC_TGT_PROG;
    end else begin
      target_of = NVAC_TGT_DATA;
    end
  endfunction : target_of

  localparam logic [31:0] STORE_LAST = 32'(STORE_CYCLES - 1);
  localparam logic [31:0] ERASE_LAST = 32'(STORE_CYCLES / 2);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic              flash_sel_ff, nxt_flash_sel;   // space select
  logic              cfg_sel_ff, nxt_cfg_sel;       // configuration select
  logic              row_wipe_ff, nxt_row_wipe;     // row erase enable
  logic              fault_ff, nxt_fault;           // store fault flag
  logic              allow_ff, nxt_allow;           // store allow
  logic              store_go_ff, nxt_store_go;     // store running
  logic              fetch_go_ff, nxt_fetch_go;     // fetch pending
  logic [7:0]        data_ff, nxt_data;             // data register
  logic [7:0]        addr_lo_ff, nxt_addr_lo;       // low address
  logic [7:0]        addr_hi_ff, nxt_addr_hi;       // high address, all bits kept
  logic              done_ff, nxt_done;             // completion flag
  logic [7:0]        rdata_ff, nxt_rdata;           // read answer
  nvac_state_t       state_ff, nxt_state;           // store sequencer
  nvac_unlock_t      unlock_ff, nxt_unlock;         // unlock tracker
  logic [31:0]       timer_ff, nxt_timer;           // store timer
  logic [31:0]       pwrup_ff, nxt_pwrup;           // power-up block timer
  logic              pwrup_done_ff, nxt_pwrup_done; // power-up period over
  logic              fault_pending_ff;              // set at reset, cleared at the first edge after release

  // decoded accesses
  logic wr_ctl, wr_unl, wr_dat, wr_alo, wr_ahi;
  logic running;

  assign running = (state_ff != NVAC_ST_IDLE);
  assign wr_ctl  = i_reg_write && (i_reg_sel == `NVAC_SEL_CONTROL);
  assign wr_unl  = i_reg_write && (i_reg_sel == `NVAC_SEL_UNLOCK);
  assign wr_dat  = i_reg_write && (i_reg_sel == `NVAC_SEL_DATA);
  assign wr_alo  = i_reg_write && (i_reg_sel == `NVAC_SEL_ADDR_LOW);
  assign wr_ahi  = i_reg_write && (i_reg_sel == `NVAC_SEL_ADDR_HIGH);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // one process computes every register but fault_pending_ff, store_cut_ff and the array outputs; writes are refused while a store runs
  always_comb begin
    nxt_flash_sel  = flash_sel_ff;
    nxt_cfg_sel    = cfg_sel_ff;
    nxt_row_wipe   = row_wipe_ff;
    nxt_fault      = fault_ff;
    nxt_allow      = allow_ff;
    nxt_store_go   = store_go_ff;
    nxt_fetch_go   = 1'b0;
    nxt_data       = data_ff;
    nxt_addr_lo    = addr_lo_ff;
    nxt_addr_hi    = addr_hi_ff;
    nxt_done       = done_ff;
    nxt_state      = state_ff;
    nxt_timer      = timer_ff;
    nxt_pwrup      = pwrup_ff;
    nxt_pwrup_done = pwrup_done_ff;
    nxt_unlock     = unlock_ff;
    nxt_rdata      = 8'h00;

    // power-up timer counts once after reset
    if (!pwrup_done_ff) begin
      if (pwrup_ff >= 32'(PWRUP_CYCLES - 1)) begin
        nxt_pwrup_done = 1'b1;
      end else begin
        nxt_pwrup = pwrup_ff + 32'h0000_0001;
      end
    end

    // unlock tracker: any register write other than the next key disarms
    if (i_reg_write) begin
      nxt_unlock = NVAC_UL_NONE;
      if (wr_unl && i_reg_wdata == `NVAC_KEY_FIRST) begin
        nxt_unlock = NVAC_UL_FIRST;
      end else if (wr_unl && i_reg_wdata == `NVAC_KEY_SECOND && unlock_ff == NVAC_UL_FIRST) begin
        nxt_unlock = NVAC_UL_ARMED;
      end
    end

    // pending fetch completes: byte lands in the data register
    if (fetch_go_ff) begin
      nxt_data = i_array_rdata;
    end

    // register writes only while idle
    if (!running) begin
      if (wr_dat) begin
        nxt_data = i_reg_wdata;
      end
      if (wr_alo) begin
        nxt_addr_lo = i_reg_wdata;
      end
      if (wr_ahi) begin
        nxt_addr_hi = i_reg_wdata;
      end
      if (wr_ctl) begin
        nxt_flash_sel = i_reg_wdata[`NVAC_BIT_FLASH];
        nxt_cfg_sel   = i_reg_wdata[`NVAC_BIT_CONFIG];
        nxt_row_wipe  = i_reg_wdata[`NVAC_BIT_ROW_WIPE];
        nxt_fault     = i_reg_wdata[`NVAC_BIT_FAULT];
        nxt_allow     = i_reg_wdata[`NVAC_BIT_ALLOW];
        // fetch only from the data array
        if (i_reg_wdata[`NVAC_BIT_FETCH_GO] && !i_reg_wdata[`NVAC_BIT_FLASH]
            && !i_reg_wdata[`NVAC_BIT_CONFIG]) begin
          nxt_fetch_go = 1'b1;
        end
        // store needs allow from an earlier write, unlock just before, timer over
        if (i_reg_wdata[`NVAC_BIT_STORE_GO]) begin
          if (allow_ff && i_reg_wdata[`NVAC_BIT_ALLOW] && unlock_ff == NVAC_UL_ARMED
              && pwrup_done_ff) begin
            nxt_store_go = 1'b1;
            nxt_timer    = 32'h0000_0000;
            nxt_state    = (row_wipe_ff || !flash_sel_ff) ? NVAC_ST_ERASE : NVAC_ST_PROG;
          end else begin
            nxt_fault = 1'b1;
          end
        end
      end
    end

    // self-timed store sequencer
    case (state_ff)
      NVAC_ST_IDLE: begin
      end
      NVAC_ST_ERASE: begin
        nxt_timer = timer_ff + 32'h0000_0001;
        // row wipe is erase only; a byte store goes on to program
        if (row_wipe_ff && timer_ff >= STORE_LAST) begin
          nxt_state    = NVAC_ST_IDLE;
          nxt_store_go = 1'b0;
          nxt_row_wipe = 1'b0;
          nxt_done     = 1'b1;
          nxt_fault    = 1'b0;
        end else if (!row_wipe_ff && timer_ff >= ERASE_LAST) begin
          nxt_state = NVAC_ST_PROG;
        end
      end
      NVAC_ST_PROG: begin
        nxt_timer = timer_ff + 32'h0000_0001;
        if (timer_ff >= STORE_LAST) begin
          nxt_state    = NVAC_ST_IDLE;
          nxt_store_go = 1'b0;
          nxt_done     = 1'b1;
          nxt_fault    = 1'b0;
        end
      end
      default: begin
        nxt_state    = NVAC_ST_IDLE;
        nxt_store_go = 1'b0;
      end
    endcase

    // software clear of the done flag loses to a completion in the same cycle
    if (i_done_clear && !(running && nxt_state == NVAC_ST_IDLE)) begin
      nxt_done = 1'b0;
    end

    // read mux
    if (i_reg_read) begin
      case (i_reg_sel)
        `NVAC_SEL_CONTROL: begin
          nxt_rdata = {flash_sel_ff, cfg_sel_ff, 1'b0, row_wipe_ff, fault_ff,
                       allow_ff, store_go_ff, fetch_go_ff};
        end
        `NVAC_SEL_UNLOCK:    nxt_rdata = 8'h00;
        `NVAC_SEL_DATA:      nxt_rdata = data_ff;
        `NVAC_SEL_ADDR_LOW:  nxt_rdata = addr_lo_ff;
        `NVAC_SEL_ADDR_HIGH: nxt_rdata = addr_hi_ff;
        default:             nxt_rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // fault and selects are not touched by reset, so a cut store can be traced
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      fault_pending_ff <= 1'b1;
      allow_ff         <= 1'b0;
      store_go_ff      <= 1'b0;
      fetch_go_ff      <= 1'b0;
      row_wipe_ff      <= 1'b0;
      done_ff          <= 1'b0;
      rdata_ff         <= 8'h00;
      state_ff         <= NVAC_ST_IDLE;
      unlock_ff        <= NVAC_UL_NONE;
      timer_ff         <= 32'h0000_0000;
      pwrup_ff         <= 32'h0000_0000;
      pwrup_done_ff    <= 1'b0;
    end else begin
      fault_pending_ff <= 1'b0;
      allow_ff         <= nxt_allow;
      store_go_ff      <= nxt_store_go;
      fetch_go_ff      <= nxt_fetch_go;
      row_wipe_ff      <= nxt_row_wipe;
      done_ff          <= nxt_done;
      rdata_ff         <= nxt_rdata;
      state_ff         <= nxt_state;
      unlock_ff        <= nxt_unlock;
      timer_ff         <= nxt_timer;
      pwrup_ff         <= nxt_pwrup;
      pwrup_done_ff    <= nxt_pwrup_done;
    end
  end

  // no-reset storage: a store cut by reset leaves store go recorded as fault
  logic store_cut_ff;
  always_ff @(posedge i_clock) begin
    // frozen while reset is held: the async reset idles the sequencer at once,
    // so sampling running during reset would lose the cut store
    if (!fault_pending_ff) begin
      store_cut_ff <= running;
    end
    flash_sel_ff  <= nxt_flash_sel;
    cfg_sel_ff    <= nxt_cfg_sel;
    data_ff       <= nxt_data;
    addr_lo_ff    <= nxt_addr_lo;
    addr_hi_ff    <= nxt_addr_hi;
    // edges while reset is held and the first edge after release: mark fault if a store was running when reset hit
    if (fault_pending_ff) begin
      fault_ff <= nxt_fault | store_cut_ff;
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // array strobes registered from the sequencer
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_array_addr     <= '0;
      o_array_wdata    <= 8'h00;
      o_array_target   <= NVAC_TGT_DATA;
      o_array_fetch    <= 1'b0;
      o_array_erase    <= 1'b0;
      o_array_prog     <= 1'b0;
      o_array_row_wipe <= 1'b0;
      o_busy           <= 1'b0;
    end else begin
      o_array_addr     <= ADDR_W'({nxt_addr_hi[1:0], nxt_addr_lo});
      o_array_wdata    <= nxt_data;
      o_array_target   <= target_of(nxt_flash_sel, nxt_cfg_sel);
      o_array_fetch    <= nxt_fetch_go;
      o_array_erase    <= (nxt_state == NVAC_ST_ERASE);
      o_array_prog     <= (nxt_state == NVAC_ST_PROG);
      o_array_row_wipe <= nxt_row_wipe && (nxt_state == NVAC_ST_ERASE);
      o_busy           <= (nxt_state != NVAC_ST_IDLE);
    end
  end

  assign o_reg_rdata    = rdata_ff;
  assign o_nv_done_flag = done_ff;

endmodule : nvac_ctrl
`default_nettype wire

/* File: rtl/nvac_pkg.sv */
// types for the nonvolatile data access controller
package nvac_pkg;
  // store sequencer states, one-hot
  typedef enum logic [2:0] {
    NVAC_ST_IDLE  = 3'b001,
    NVAC_ST_ERASE = 3'b010,
    NVAC_ST_PROG  = 3'b100
  } nvac_state_t;
  // unlock tracker states, one-hot
  typedef enum logic [2:0] {
    NVAC_UL_NONE  = 3'b001,
    NVAC_UL_FIRST = 3'b010,
    NVAC_UL_ARMED = 3'b100
  } nvac_unlock_t;
  // target space of an access
  typedef enum logic [1:0] {
    NVAC_TGT_DATA   = 2'h0,
    NVAC_TGT_PROG   = 2'h1,
    NVAC_TGT_CONFIG = 2'h2
  } nvac_target_t;
endpackage : nvac_pkg
